// ==== verilog/pxc_ext_cap_regs.sv ====
/*
 * Port extended-capability register bank of a switch port: the error
 * header log, the serial number capability and the head of the virtual
 * channel capability, reached over AXI4-Lite.
 * Assumes reset_n is the power-on reset; port_reset is the ordinary
 * (non power-on) reset, which leaves sticky fields untouched. All inputs
 * come from logic on clk.
 */
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module pxc_ext_cap_regs
   import pxc_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic         port_reset,
   input  wire logic         write_lock,
   input  wire logic         is_upstream,
   input  wire logic         err_report,
   input  wire logic [127:0] err_header,
   input  wire logic [4:0]   err_status_bit,
   input  wire logic         err_log_rearm,
   output logic              log_held,
   input  wire logic [11:0]  s_axi_awaddr,
   input  wire logic         s_axi_awvalid,
   output logic              s_axi_awready,
   input  wire logic [31:0]  s_axi_wdata,
   input  wire logic [3:0]   s_axi_wstrb,
   input  wire logic         s_axi_wvalid,
   output logic              s_axi_wready,
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  wire logic         s_axi_bready,
   input  wire logic [11:0]  s_axi_araddr,
   input  wire logic         s_axi_arvalid,
   output logic              s_axi_arready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  wire logic         s_axi_rready
);
`include "pxc_params.svh"

   pxc_reg_if       regs ();
   pxc_bank_state_t st;
   pxc_bank_state_t next_st;
   logic [31:0]     merged;
   logic [31:0]     rd_word;
   logic            rd_hit;
   logic            wr_hit;
   logic            log_hit;
   logic [1:0]      log_sel;

   // byte-lane merge of a write into an old word
   function automatic logic [31:0] lane_merge(
      input logic [31:0] old_word,
      input logic [31:0] new_word,
      input logic [3:0]  strb
   );
      logic [31:0] res;
      res = old_word;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_word[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // header-log window match: word-aligned and inside the four words
   function automatic logic in_log_window(input logic [11:0] addr);
      logic [11:0] delta;
      delta = addr - `PXC_OFF_HDR_LOG_DW1;
      return (addr >= `PXC_OFF_HDR_LOG_DW1) &&
             (delta[11:2] < {7'h00, `PXC_HDR_LOG_WORDS}) &&
             (delta[1:0] == 2'h0);
   endfunction

   // capability header word from its fixed id and its pointer
   function automatic logic [31:0] cap_header(
      input logic [15:0] cap_id,
      input logic [11:0] next_ptr
   );
      logic [31:0] w;
      w = `PXC_WORD_RESET;
      w[`PXC_CAP_ID_MSB:`PXC_CAP_ID_LSB]     = cap_id;
      w[`PXC_CAP_VER_MSB:`PXC_CAP_VER_LSB]   = `PXC_CAP_VERSION;
      w[`PXC_NEXT_PTR_MSB:`PXC_NEXT_PTR_LSB] = next_ptr;
      return w;
   endfunction

   // header-log word select shared by reads
   assign log_hit = in_log_window(regs.rd_addr);
   assign log_sel = 2'((regs.rd_addr - `PXC_OFF_HDR_LOG_DW1) >> 2);

   // read decode; unmapped addresses read zero with an error answer
   always_comb begin
      rd_word = `PXC_WORD_RESET;
      rd_hit  = 1'b1;
      if (log_hit) begin
         rd_word = st.hdr_log[log_sel];
      end else begin
         unique case (regs.rd_addr)
            `PXC_OFF_SERIAL_HDR: begin
               rd_word = cap_header(`PXC_SERIAL_CAP_ID,
                                    st.serial_next_ptr);
            end
            `PXC_OFF_SERIAL_LOW: begin
               rd_word = st.serial_low;
            end
            `PXC_OFF_SERIAL_HIGH: begin
               rd_word = st.serial_high;
            end
            `PXC_OFF_VCHAN_HDR: begin
               rd_word = cap_header(`PXC_VCHAN_CAP_ID,
                                    st.vchan_next_ptr);
            end
            `PXC_OFF_VCHAN_CAPS1: begin
               // fixed fields; bits 3, 7 and 31:12 stay zero
               rd_word[2:0]   = `PXC_EXTRA_VC_COUNT;
               rd_word[6:4]   = `PXC_LOWPRIO_VC_COUNT;
               rd_word[9:8]   = `PXC_ARB_TIME_BASE;
               // upstream table uses 4-bit entries
               rd_word[11:10] = st.upstream ?
                                `PXC_ENTRY_SIZE_4BIT :
                                `PXC_ENTRY_SIZE_1BIT;
            end
            `PXC_OFF_ERR_INDEX: begin
               rd_word[`PXC_ERR_INDEX_MSB:0] =
                  st.first_error_index;
               rd_word[`PXC_LOG_HELD_BIT] = st.log_held;
            end
            default: begin
               rd_hit = 1'b0;
            end
         endcase
      end
   end

   assign regs.rd_data = rd_word;
   assign regs.rd_hit  = rd_hit;

   // write decode: read-only words answer okay and change nothing
   always_comb begin
      unique case (regs.wr_addr)
         `PXC_OFF_SERIAL_HDR,
         `PXC_OFF_SERIAL_LOW,
         `PXC_OFF_SERIAL_HIGH,
         `PXC_OFF_VCHAN_HDR,
         `PXC_OFF_VCHAN_CAPS1,
         `PXC_OFF_ERR_INDEX: begin
            wr_hit = 1'b1;
         end
         default: begin
            wr_hit = in_log_window(regs.wr_addr);
         end
      endcase
   end

   assign regs.wr_hit = wr_hit;

   // incoming write after byte-lane merge against the target's old value
   always_comb begin
      unique case (regs.wr_addr)
         `PXC_OFF_SERIAL_LOW: begin
            merged = lane_merge(st.serial_low, regs.wr_data, regs.wr_strb);
         end
         `PXC_OFF_SERIAL_HIGH: begin
            merged = lane_merge(st.serial_high, regs.wr_data, regs.wr_strb);
         end
         `PXC_OFF_SERIAL_HDR: begin
            merged = lane_merge(cap_header(`PXC_SERIAL_CAP_ID,
                                           st.serial_next_ptr),
                                regs.wr_data, regs.wr_strb);
         end
         `PXC_OFF_VCHAN_HDR: begin
            merged = lane_merge(cap_header(`PXC_VCHAN_CAP_ID,
                                           st.vchan_next_ptr),
                                regs.wr_data, regs.wr_strb);
         end
         default: begin
            merged = regs.wr_data;
         end
      endcase
   end

   // bank next state: capture, software writes, ordinary reset, power-on
   always_comb begin
      next_st = st;

      // software re-arms the log; a report in the same cycle still lands
      if (err_log_rearm) begin
         next_st.log_held = 1'b0;
      end
      if (err_report && (!st.log_held || err_log_rearm)) begin
         for (int i = 0; i < 4; i++) begin
            next_st.hdr_log[i] = err_header[i*32 +: 32];
         end
         next_st.first_error_index = err_status_bit;
         next_st.log_held          = 1'b1;
      end

      // lockable fields only move while the lock is open
      if (regs.wr_en && !write_lock) begin
         unique case (regs.wr_addr)
            `PXC_OFF_SERIAL_LOW: begin
               next_st.serial_low = merged;
            end
            `PXC_OFF_SERIAL_HIGH: begin
               next_st.serial_high = merged;
            end
            `PXC_OFF_SERIAL_HDR: begin
               next_st.serial_next_ptr =
                  merged[`PXC_NEXT_PTR_MSB:`PXC_NEXT_PTR_LSB];
            end
            `PXC_OFF_VCHAN_HDR: begin
               next_st.vchan_next_ptr =
                  merged[`PXC_NEXT_PTR_MSB:`PXC_NEXT_PTR_LSB];
            end
            default: begin
               // read-only and reserved words ignore writes
            end
         endcase
      end

      // ordinary reset clears only the non-sticky pointers
      if (port_reset) begin
         next_st.serial_next_ptr = `PXC_NEXT_PTR_RESET;
         next_st.vchan_next_ptr  = `PXC_NEXT_PTR_RESET;
      end

      // power-on reset clears all; strap is caught while reset is held
      if (!reset_n) begin
         next_st                   = '0;
         next_st.hdr_log           = '0;
         next_st.first_error_index = `PXC_INDEX_RESET;
         next_st.serial_low        = `PXC_WORD_RESET;
         next_st.serial_high       = `PXC_WORD_RESET;
         next_st.serial_next_ptr   = `PXC_NEXT_PTR_RESET;
         next_st.vchan_next_ptr    = `PXC_NEXT_PTR_RESET;
         next_st.upstream          = is_upstream;
      end
   end

   // single state register of the bank
   always_ff @(posedge clk) begin
      st <= next_st;
   end

   assign log_held = st.log_held;

   // bus front end
   pxc_axil_slave u_bus (
      .clk           (clk),
      .reset_n       (reset_n),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .regs          (regs.bus_side)
   );

endmodule // pxc_ext_cap_regs

// ==== verilog/pxc_params.svh ====
/*
 * Register offsets, field positions, fixed field values and reset values
 * of the port extended-capability register block.
 * Assumes 12-bit configuration-space byte addresses, one word per register.
 */
`ifndef PXC_PARAMS_SVH
`define PXC_PARAMS_SVH

// register byte offsets
`define PXC_OFF_HDR_LOG_DW1   12'h11C
`define PXC_OFF_HDR_LOG_DW2   12'h120
`define PXC_OFF_HDR_LOG_DW3   12'h124
`define PXC_OFF_HDR_LOG_DW4   12'h128
`define PXC_OFF_SERIAL_HDR    12'h180
`define PXC_OFF_SERIAL_LOW    12'h184
`define PXC_OFF_SERIAL_HIGH   12'h188
`define PXC_OFF_VCHAN_HDR     12'h200
`define PXC_OFF_VCHAN_CAPS1   12'h204
`define PXC_OFF_ERR_INDEX     12'h1F0

// header-log window, word index range of the four doublewords
`define PXC_HDR_LOG_WORDS     3'h4

// capability header fields
`define PXC_CAP_ID_LSB        0
`define PXC_CAP_ID_MSB        15
`define PXC_CAP_VER_LSB       16
`define PXC_CAP_VER_MSB       19
`define PXC_NEXT_PTR_LSB      20
`define PXC_NEXT_PTR_MSB      31
`define PXC_SERIAL_CAP_ID     16'h0003
`define PXC_VCHAN_CAP_ID      16'h0002
`define PXC_CAP_VERSION       4'h1
`define PXC_NEXT_PTR_RESET    12'h000

// port vc capability 1 fields
`define PXC_EXTRA_VC_COUNT    3'h0
`define PXC_LOWPRIO_VC_COUNT  3'h0
`define PXC_ARB_TIME_BASE     2'h0
`define PXC_ENTRY_SIZE_1BIT   2'h0
`define PXC_ENTRY_SIZE_2BIT   2'h1
`define PXC_ENTRY_SIZE_4BIT   2'h2
`define PXC_ENTRY_SIZE_8BIT   2'h3

// first-error index register fields
`define PXC_ERR_INDEX_MSB     4
`define PXC_LOG_HELD_BIT      8

// reset values
`define PXC_WORD_RESET        32'h0000_0000
`define PXC_INDEX_RESET       5'h00

// axi response codes
`define PXC_RESP_OKAY         2'h0
`define PXC_RESP_SLVERR       2'h2

`endif

// ==== verilog/pxc_pkg.sv ====
/*
 * Types of the port extended-capability register block: the state records
 * of the bus slave and of the register bank.
 * Assumes pxc_params.svh for the numeric constants.
 */
package pxc_pkg;

   // state of the axi4-lite front end
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic        have_aw;
      logic        have_w;
      logic        rd_pend;
      logic [11:0] waddr;
      logic [11:0] raddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
   } pxc_axi_state_t;

   // state of the register bank
   typedef struct packed {
      logic [3:0][31:0] hdr_log;
      logic [4:0]       first_error_index;
      logic             log_held;
      logic [31:0]      serial_low;
      logic [31:0]      serial_high;
      logic [11:0]      serial_next_ptr;
      logic [11:0]      vchan_next_ptr;
      logic             upstream;
   } pxc_bank_state_t;

endpackage

// ==== verilog/pxc_reg_if.sv ====
/*
 * Internal register access port between the bus front end and the bank.
 * Assumes one clock; requests are single-cycle strobes, answers are
 * combinational in the same cycle.
 */
`timescale 1ns/10ps
interface pxc_reg_if;
   logic        wr_en;
   logic [11:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;
   logic        wr_hit;
   logic        rd_en;
   logic [11:0] rd_addr;
   logic [31:0] rd_data;
   logic        rd_hit;

   modport bus_side (
      output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
      input  wr_hit, rd_data, rd_hit
   );
   modport bank_side (
      input  wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
      output wr_hit, rd_data, rd_hit
   );
endinterface // pxc_reg_if

// ==== verilog/pxc_axil_slave.sv ====
/*
 * AXI4-Lite slave front end: takes address and data in either order,
 * issues one strobe to the bank, answers one cycle later.
 * Assumes a master that keeps one write and one read under way at a time.
 */
`timescale 1ns/10ps
module pxc_axil_slave
   import pxc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   pxc_reg_if.bus_side      regs
);
`include "pxc_params.svh"

   pxc_axi_state_t st;
   pxc_axi_state_t next_st;
   logic           do_write;

   // write fires once both halves are held and the last answer is gone
   assign do_write      = st.have_aw && st.have_w && !st.bvalid;
   assign regs.wr_en    = do_write;
   assign regs.wr_addr  = st.waddr;
   assign regs.wr_data  = st.wdata;
   assign regs.wr_strb  = st.wstrb;
   assign regs.rd_en    = st.rd_pend;
   assign regs.rd_addr  = st.raddr;

   // next-state logic of both channels
   always_comb begin
      next_st = st;
      if (s_axi_awvalid && st.awready) begin
         next_st.have_aw = 1'b1;
         next_st.waddr   = s_axi_awaddr;
      end
      if (s_axi_wvalid && st.wready) begin
         next_st.have_w = 1'b1;
         next_st.wdata  = s_axi_wdata;
         next_st.wstrb  = s_axi_wstrb;
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      if (do_write) begin
         next_st.have_aw = 1'b0;
         next_st.have_w  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = regs.wr_hit ? `PXC_RESP_OKAY : `PXC_RESP_SLVERR;
      end
      if (s_axi_arvalid && st.arready) begin
         next_st.rd_pend = 1'b1;
         next_st.raddr   = s_axi_araddr;
      end
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
      if (st.rd_pend) begin
         next_st.rd_pend = 1'b0;
         next_st.rvalid  = 1'b1;
         next_st.rdata   = regs.rd_data;
         next_st.rresp   = regs.rd_hit ? `PXC_RESP_OKAY : `PXC_RESP_SLVERR;
      end
      // readies from flops, so they drop the cycle a request is taken
      next_st.awready = !next_st.have_aw;
      next_st.wready  = !next_st.have_w;
      next_st.arready = !next_st.rd_pend && !next_st.rvalid;
      if (!reset_n) begin
         next_st = '0;
      end
   end

   // single state register
   always_ff @(posedge clk) begin
      st <= next_st;
   end

   assign s_axi_awready = st.awready;
   assign s_axi_wready  = st.wready;
   assign s_axi_bvalid  = st.bvalid;
   assign s_axi_bresp   = st.bresp;
   assign s_axi_arready = st.arready;
   assign s_axi_rvalid  = st.rvalid;
   assign s_axi_rdata   = st.rdata;
   assign s_axi_rresp   = st.rresp;

endmodule // pxc_axil_slave

// ==== verification/pxc_ext_cap_regs_props.sv ====
/* checker: bus answer timing, fixed capability fields and log holding
   of the register bank. assumes one clock and a bind to the bank top. */
`timescale 1ns/10ps
module pxc_ext_cap_regs_props (
   input wire logic         clk,
   input wire logic         reset_n,
   input wire logic         port_reset,
   input wire logic         write_lock,
   input wire logic         is_upstream,
   input wire logic         err_report,
   input wire logic [127:0] err_header,
   input wire logic [4:0]   err_status_bit,
   input wire logic         err_log_rearm,
   input wire logic         log_held,
   input wire logic [11:0]  s_axi_awaddr,
   input wire logic         s_axi_awvalid,
   input wire logic         s_axi_awready,
   input wire logic [31:0]  s_axi_wdata,
   input wire logic [3:0]   s_axi_wstrb,
   input wire logic         s_axi_wvalid,
   input wire logic         s_axi_wready,
   input wire logic [1:0]   s_axi_bresp,
   input wire logic         s_axi_bvalid,
   input wire logic         s_axi_bready,
   input wire logic [11:0]  s_axi_araddr,
   input wire logic         s_axi_arvalid,
   input wire logic         s_axi_arready,
   input wire logic [31:0]  s_axi_rdata,
   input wire logic [1:0]   s_axi_rresp,
   input wire logic         s_axi_rvalid,
   input wire logic         s_axi_rready
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // a read taken at a given address, and its two-edge answer
   sequence rd_take(logic [11:0] a);
      s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
   endsequence
   sequence rd_answer;
      ##1 (!s_axi_arready && !s_axi_rvalid) ##1 s_axi_rvalid;
   endsequence

   read_lat_a:
      assert property (s_axi_arvalid && s_axi_arready |-> rd_answer)
      else $error("read answer not two edges after address");
   rd_hold_a:
      assert property (s_axi_rvalid && !s_axi_rready
                       |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before taken");
   wr_hold_a:
      assert property (s_axi_bvalid && !s_axi_bready
                       |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");
   serial_hdr_a:
      assert property (rd_take(12'h180) |-> ##2 s_axi_rdata[19:0] == 20'h10003)
      else $error("serial header id or version wrong");
   vchan_hdr_a:
      assert property (rd_take(12'h200) |-> ##2 s_axi_rdata[19:0] == 20'h10002)
      else $error("channel header id or version wrong");
   vc_fixed_a:
      assert property (rd_take(12'h204) |-> ##2
         {s_axi_rdata[31:12], s_axi_rdata[9:0]} == 30'h0)
      else $error("channel caps fixed bits not zero");
   unaligned_a:
      assert property (s_axi_arvalid && s_axi_arready
         && s_axi_araddr[1:0] != 2'h0
         |-> ##2 s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("unaligned read not refused");
   log_set_a:
      assert property (err_report && !log_held |=> log_held)
      else $error("first error not held");
   log_keep_a:
      assert property (log_held && !err_log_rearm |=> log_held)
      else $error("held log lost without rearm");
   log_free_a:
      assert property (log_held && err_log_rearm && !err_report
                       |=> !log_held)
      else $error("rearm did not free the log");
endmodule // pxc_ext_cap_regs_props

bind pxc_ext_cap_regs pxc_ext_cap_regs_props u_props (.*);

// ==== verification/testbench.sv ====
/* self-checking bench of the port extended-capability register bank.
   assumes pxc_params.svh on the include path. */
`timescale 1ns/10ps
`include "pxc_params.svh"
module testbench;
   typedef struct {logic wr; logic [31:0] d; logic [1:0] r;} pxc_note_t;
   logic         clk, reset_n, port_reset, write_lock, is_upstream;
   logic         err_report, err_log_rearm, log_held;
   logic [127:0] err_header, hdr;
   logic [4:0]   err_status_bit, idx;
   logic [11:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0]  s_axi_wdata, s_axi_rdata, ser_lo, ser_hi;
   logic [3:0]   s_axi_wstrb;
   logic [1:0]   s_axi_bresp, s_axi_rresp;
   logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic         s_axi_rvalid, s_axi_rready;
   int           num_errors, cmp_count, i;
   pxc_note_t    notes[$];

   pxc_ext_cap_regs u_pxc_ext_cap_regs (.*);

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task chk(string n, logic [31:0] e, logic [31:0] s);
      cmp_count++;
      if (e !== s) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", n, e, s);
      end
   endtask

   task final_report;
      $display("mismatches %0d, compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // answers are judged at the negedge before the edge that takes them
   always @(negedge clk) begin
      pxc_note_t n;
      if (reset_n && ((s_axi_rvalid && s_axi_rready)
                      || (s_axi_bvalid && s_axi_bready))) begin
         if (notes.size() == 0)
            chk("note queue", 32'h0, 32'h1);
         else begin
            n = notes.pop_front();
            if (n.wr)
               chk("bresp", {30'h0, n.r}, {30'h0, s_axi_bresp});
            else begin
               chk("rdata", n.d, s_axi_rdata);
               chk("rresp", {30'h0, n.r}, {30'h0, s_axi_rresp});
            end
         end
      end
   end

   // one write; handshakes seen at negedge, released after the edge
   task wr(logic [11:0] a, logic [31:0] d, logic [3:0] s, logic [1:0] er);
      logic aw, w, b;
      notes.push_back('{1'b1, 32'h0, er});
      @(posedge clk);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      b = 1'b0;
      for (int n = 0; n < 50 && !b; n++) begin
         @(negedge clk);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         @(posedge clk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         if (b) s_axi_bready <= 1'b0;
      end
      if (!b) begin
         num_errors++;
         final_report;
      end
   endtask

   // one read; expected word and code go to the note queue
   task rd(logic [11:0] a, logic [31:0] e, logic [1:0] er);
      logic ar, r;
      notes.push_back('{1'b0, e, er});
      @(posedge clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      r = 1'b0;
      for (int n = 0; n < 50 && !r; n++) begin
         @(negedge clk);
         ar = s_axi_arvalid && s_axi_arready;
         r = s_axi_rvalid;
         @(posedge clk);
         if (ar) s_axi_arvalid <= 1'b0;
         if (r) s_axi_rready <= 1'b0;
      end
      if (!r) begin
         num_errors++;
         final_report;
      end
   endtask

   task err_pulse(logic [127:0] h, logic [4:0] x, logic ra = 1'b0);
      @(posedge clk);
      err_report     <= 1'b1;
      err_log_rearm  <= ra;
      err_header     <= h;
      err_status_bit <= x;
      @(posedge clk);
      {err_report, err_log_rearm} <= 2'h0;
   endtask

   // four logged words plus the index word with its held flag
   task check_log(logic [127:0] h, logic [4:0] x);
      for (int k = 0; k < 4; k++)
         rd(12'h11C + 12'(k*4), h[32*k+:32], `PXC_RESP_OKAY);
      rd(12'h1F0, {23'h0, 1'b1, 3'h0, x}, `PXC_RESP_OKAY);
   endtask

   initial begin
      {reset_n, port_reset, write_lock, err_report, err_log_rearm} = 5'h00;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {err_header, err_status_bit} = '0;
      is_upstream = 1'b1;
      void'($urandom(32'h30A38C44));
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      // reset values and refusals of unmapped places
      for (i = 0; i < 4; i++)
         rd(12'h11C + 12'(i * 4), 32'h0, `PXC_RESP_OKAY);
      rd(12'h180, 32'h0001_0003, `PXC_RESP_OKAY);
      rd(12'h184, 32'h0, `PXC_RESP_OKAY);
      rd(12'h188, 32'h0, `PXC_RESP_OKAY);
      rd(12'h200, 32'h0001_0002, `PXC_RESP_OKAY);
      rd(12'h204, 32'h800, `PXC_RESP_OKAY);
      rd(12'h1F0, 32'h0, `PXC_RESP_OKAY);
      rd(12'h12C, 32'h0, `PXC_RESP_SLVERR);
      rd(12'h11E, 32'h0, `PXC_RESP_SLVERR);
      // writable identifier halves, byte strobes, read-only places
      ser_lo = $urandom;
      ser_hi = $urandom;
      wr(12'h184, ser_lo, 4'hF, `PXC_RESP_OKAY);
      wr(12'h188, ser_hi, 4'hF, `PXC_RESP_OKAY);
      wr(12'h184, ~ser_lo, 4'h1, `PXC_RESP_OKAY);
      ser_lo[7:0] = ~ser_lo[7:0];
      rd(12'h184, ser_lo, `PXC_RESP_OKAY);
      rd(12'h188, ser_hi, `PXC_RESP_OKAY);
      wr(12'h11C, $urandom, 4'hF, `PXC_RESP_OKAY);
      rd(12'h11C, 32'h0, `PXC_RESP_OKAY);
      wr(12'h204, 32'hFFFF_FFFF, 4'hF, `PXC_RESP_OKAY);
      rd(12'h204, 32'h0000_0800, `PXC_RESP_OKAY);
      wr(12'h180, 32'hFFFF_FFFF, 4'hF, `PXC_RESP_OKAY);
      rd(12'h180, 32'hFFF1_0003, `PXC_RESP_OKAY);
      wr(12'h200, 32'hABC0_0000, 4'hF, `PXC_RESP_OKAY);
      rd(12'h200, 32'hABC1_0002, `PXC_RESP_OKAY);
      wr(12'h300, 32'h1, 4'hF, `PXC_RESP_SLVERR);
      // lock holds the lockable words
      @(posedge clk);
      write_lock <= 1'b1;
      wr(12'h184, $urandom, 4'hF, `PXC_RESP_OKAY);
      wr(12'h200, 32'h0, 4'hF, `PXC_RESP_OKAY);
      rd(12'h184, ser_lo, `PXC_RESP_OKAY);
      rd(12'h200, 32'hABC1_0002, `PXC_RESP_OKAY);
      @(posedge clk);
      write_lock <= 1'b0;
      // first error captured, later ones dropped, ordinary reset kept out
      hdr = {$urandom, $urandom, $urandom, $urandom};
      idx = 5'($urandom);
      err_pulse(hdr, idx);
      @(negedge clk);
      chk("log_held", 32'h1, {31'h0, log_held});
      check_log(hdr, idx);
      err_pulse(~hdr, ~idx);
      @(posedge clk);
      port_reset <= 1'b1;
      @(posedge clk);
      port_reset <= 1'b0;
      check_log(hdr, idx);
      rd(12'h184, ser_lo, `PXC_RESP_OKAY);
      rd(12'h180, 32'h0001_0003, `PXC_RESP_OKAY);
      // rearm frees the log for the next first error
      @(posedge clk);
      err_log_rearm <= 1'b1;
      @(posedge clk);
      err_log_rearm <= 1'b0;
      @(negedge clk);
      chk("log_held", 32'h0, {31'h0, log_held});
      err_pulse(~hdr, ~idx);
      check_log(~hdr, ~idx);
      // rearm and report together
      err_pulse(hdr, idx, 1'b1);
      check_log(hdr, idx);
      // power-on reset clears sticky words, downstream strap
      @(posedge clk);
      reset_n     <= 1'b0;
      is_upstream <= 1'b0;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      rd(12'h184, 32'h0, `PXC_RESP_OKAY);
      rd(12'h11C, 32'h0, `PXC_RESP_OKAY);
      rd(12'h1F0, 32'h0, `PXC_RESP_OKAY);
      rd(12'h204, 32'h0, `PXC_RESP_OKAY);
      repeat (2) @(posedge clk);
      final_report;
   end
endmodule // testbench
